// >>> rtl/link_sync_alarm_monitor.sv
// Converter-side link clocking, link start-up and alarm monitor
`timescale 1ns/10ps
`default_nettype none
// Overview of operation
// - SYSREF resets multiframe or multiblock clock
// - Receiver offsets release point by RBD
// - Lanes arrive between two release points
// - Release only after all lanes arrived
// - Subclass 0 free-runs local multiframe clock
// - SYNC low starts CGS then ILAS
// - Six alarm sources detected
// - Alarm bits sticky, write one clears
// - Unmasked alarms reach summary flag
// - Alarm pin select drives pin from summary flag
// - Channel clock mismatch sets sticky upset
// - Host re-enables link, clears upset flag
// - Power-down exit may set upset flag
// - Pointer upset flags affected lane only
// - Link enable toggle resets FIFO logic
// - Link disabled: reset, serializers off, gated
module link_sync_alarm_monitor
  import link_sync_pkg::*;
#(
  parameter int LANES      = 4,
  parameter int EMB_FRAMES = 32
) (
  input  wire logic               mclk,
  input  wire logic               rstn,
  input  wire logic [7:0]         addr,
  input  wire logic [31:0]        wdata,
  input  wire logic               wr,
  input  wire logic               rd,
  output logic      [31:0]        rdata,
  input  wire logic               cpll_locked,
  input  wire logic               spll_locked,
  input  wire logic               clk_a_phase,
  input  wire logic               clk_b_phase,
  input  wire logic [LANES-1:0]   fifo_ptr_upset,
  input  wire logic               powerdown_pin,
  input  wire logic               cal_done,
  input  wire logic [LANES*8-1:0] sample_data,
  output logic                    calibration_status_pin,
  output logic                    link_reset_n,
  output logic                    serializer_powerdown,
  output logic                    link_clock_gate_en,
  output logic                    lmfc_edge,
  link_if.device                  link
);

  logic [15:0]      ctrl;
  logic [ALM_W-1:0] alarm_status_bits;
  logic [ALM_W-1:0] alarm_type_mask;
  logic             clock_upset_flag;
  logic [LANES-1:0] lane_fifo_upset_flags;
  logic             summary;
  logic             link_enable;
  logic             enc_64b;
  logic             subclass0;
  logic [8:0]       lmfc_count;
  logic [8:0]       lmfc_last;
  logic             sysref_q;
  logic             sysref_capture;
  logic             sysref_realign;
  logic             pd_q;
  logic             global_pd;
  logic [10:0]      ilas_count;
  logic [10:0]      ilas_last;
  logic [ALM_W-1:0] alarm_events;
  tx_state_e        state;
  tx_state_e        next_state;

  assign link_enable = ctrl[CTRL_LINK_EN];
  assign enc_64b     = ctrl[CTRL_ENC_64B];
  assign subclass0   = ctrl[CTRL_SUBCLASS0];
  assign global_pd   = ctrl[CTRL_GLOBAL_PD] | powerdown_pin;

  ////////////////////////////////////////////////////////////////////////
  // Register port

  always_ff @(posedge mclk or negedge rstn) begin
    if (!rstn) begin
      ctrl <= CTRL_RESET;
    end else if (wr && addr == REG_CTRL) begin
      ctrl <= wdata[15:0];
    end
  end

  always_ff @(posedge mclk or negedge rstn) begin
    if (!rstn) begin
      alarm_type_mask <= ALARM_MASK_RESET;
    end else if (wr && addr == REG_ALARM_MASK) begin
      alarm_type_mask <= wdata[ALM_W-1:0];
    end
  end

  assign summary = |(alarm_status_bits & ~alarm_type_mask);

  // Unmapped offsets read as zero
  always_ff @(posedge mclk or negedge rstn) begin
    if (!rstn) begin
      rdata <= 32'h0;
    end else if (rd) begin
      unique case (addr)
        REG_CTRL:        rdata <= {16'h0, ctrl};
        REG_ALARM:       rdata <= {{(32-ALM_W){1'b0}}, alarm_status_bits};
        REG_ALARM_MASK:  rdata <= {{(32-ALM_W){1'b0}}, alarm_type_mask};
        REG_SUMMARY:     rdata <= {31'h0, summary};
        REG_CLOCK_UPSET: rdata <= {31'h0, clock_upset_flag};
        REG_LANE_FIFO:   rdata <= {{(32-LANES){1'b0}}, lane_fifo_upset_flags};
        REG_LINK_STATE:  rdata <= {28'h0, state};
        default:         rdata <= 32'h0;
      endcase
    end else begin
      rdata <= 32'h0;
    end
  end

  ////////////////////////////////////////////////////////////////////////
  // Local multiframe / extended multiblock clock

  assign lmfc_last = enc_64b ? 9'(EMB_FRAMES - 1) : {1'b0, ctrl[CTRL_KM1_LO +: 8]};

  always_ff @(posedge mclk or negedge rstn) begin
    if (!rstn) begin
      sysref_q <= 1'b0;
    end else begin
      sysref_q <= link.sysref;
    end
  end

  assign sysref_capture = link.sysref & ~sysref_q & ~subclass0;
  // Only a phase change counts as a realignment
  assign sysref_realign = sysref_capture && lmfc_count != lmfc_last;

  always_ff @(posedge mclk or negedge rstn) begin
    if (!rstn) begin
      lmfc_count <= 9'h0;
    end else if (sysref_capture) begin
      lmfc_count <= 9'h0;
    end else if (lmfc_count >= lmfc_last) begin
      lmfc_count <= 9'h0;
    end else begin
      lmfc_count <= lmfc_count + 9'h1;
    end
  end

  always_ff @(posedge mclk or negedge rstn) begin
    if (!rstn) begin
      lmfc_edge <= 1'b0;
    end else begin
      lmfc_edge <= sysref_capture || lmfc_count >= lmfc_last;
    end
  end

  ////////////////////////////////////////////////////////////////////////
  // Link start-up sequence

  assign ilas_last = enc_64b ? 11'h0 : 11'((lmfc_last + 9'h1) * ILAS_MULTIFRAMES - 1);

  always_comb begin
    next_state = state;
    unique case (state)
      TX_OFF:  if (link_enable) next_state = enc_64b ? TX_ILAS : TX_CGS;
      // CGS until SYNC released, start on multiframe clock edge
      TX_CGS:  if (link.sync_n && lmfc_edge) next_state = TX_ILAS;
      TX_ILAS: if (!enc_64b && !link.sync_n) next_state = TX_CGS;
               else if (ilas_count == ilas_last) next_state = TX_DATA;
      TX_DATA: if (!enc_64b && !link.sync_n) next_state = TX_CGS;
      default: next_state = TX_OFF;
    endcase
    if (!link_enable) next_state = TX_OFF;
  end

  always_ff @(posedge mclk or negedge rstn) begin
    if (!rstn) begin
      state <= TX_OFF;
    end else begin
      state <= next_state;
    end
  end

  always_ff @(posedge mclk or negedge rstn) begin
    if (!rstn) begin
      ilas_count <= 11'h0;
    end else if (state == TX_ILAS) begin
      ilas_count <= ilas_count + 11'h1;
    end else begin
      ilas_count <= 11'h0;
    end
  end

  always_ff @(posedge mclk or negedge rstn) begin
    if (!rstn) begin
      link.tx_data <= '0;
      link.tx_ctrl <= '0;
    end else begin
      unique case (next_state)
        TX_CGS: begin
          link.tx_data <= {LANES{CHAR_CGS}};
          link.tx_ctrl <= '1;
        end
        TX_ILAS: begin
          link.tx_data <= (state != TX_ILAS) ? {LANES{CHAR_ALIGN_START}} : '0;
          link.tx_ctrl <= (state != TX_ILAS) ? '1 : '0;
        end
        TX_DATA: begin
          link.tx_data <= sample_data;
          link.tx_ctrl <= '0;
        end
        default: begin
          link.tx_data <= '0;
          link.tx_ctrl <= '0;
        end
      endcase
    end
  end

  // Held in reset, powered down and gated while the link is disabled
  always_ff @(posedge mclk or negedge rstn) begin
    if (!rstn) begin
      link_reset_n         <= 1'b0;
      serializer_powerdown <= 1'b1;
      link_clock_gate_en   <= 1'b0;
    end else begin
      link_reset_n         <= link_enable;
      serializer_powerdown <= ~link_enable;
      link_clock_gate_en   <= link_enable;
    end
  end

  ////////////////////////////////////////////////////////////////////////
  // Clock and FIFO upset flags

  always_ff @(posedge mclk or negedge rstn) begin
    if (!rstn) begin
      pd_q <= 1'b0;
    end else begin
      pd_q <= global_pd;
    end
  end

  // Set wins over a same-cycle clear
  always_ff @(posedge mclk or negedge rstn) begin
    if (!rstn) begin
      clock_upset_flag <= 1'b0;
    end else if (link_enable && !ctrl[CTRL_PD_A] && !ctrl[CTRL_PD_B] && clk_a_phase != clk_b_phase) begin
      clock_upset_flag <= 1'b1;
    end else if (pd_q && !global_pd) begin
      clock_upset_flag <= 1'b1;
    end else if (wr && addr == REG_CLOCK_UPSET && wdata[0]) begin
      clock_upset_flag <= 1'b0;
    end
  end

  // FIFO logic sits in reset while the link is off
  always_ff @(posedge mclk or negedge rstn) begin
    if (!rstn) begin
      lane_fifo_upset_flags <= '0;
    end else if (!link_enable) begin
      lane_fifo_upset_flags <= '0;
    end else begin
      lane_fifo_upset_flags <= (lane_fifo_upset_flags
        & ~((wr && addr == REG_LANE_FIFO) ? wdata[LANES-1:0] : {LANES{1'b0}}))
        | fifo_ptr_upset;
    end
  end

  ////////////////////////////////////////////////////////////////////////
  // Alarm status and pin

  always_comb begin
    alarm_events                = '0;
    alarm_events[ALM_CPLL]      = ~cpll_locked;
    alarm_events[ALM_SPLL]      = ~spll_locked;
    alarm_events[ALM_LINK_DOWN] = state != TX_DATA;
    alarm_events[ALM_SYSREF]    = sysref_realign;
    alarm_events[ALM_CLOCK]     = clock_upset_flag;
    alarm_events[ALM_FIFO]      = |lane_fifo_upset_flags;
  end

  // Zeros in the write are ignored
  always_ff @(posedge mclk or negedge rstn) begin
    if (!rstn) begin
      alarm_status_bits <= '0;
    end else begin
      alarm_status_bits <= (alarm_status_bits
        & ~((wr && addr == REG_ALARM) ? wdata[ALM_W-1:0] : {ALM_W{1'b0}}))
        | alarm_events;
    end
  end

  always_ff @(posedge mclk or negedge rstn) begin
    if (!rstn) begin
      calibration_status_pin <= 1'b0;
    end else if (ctrl[CTRL_PIN_SEL_LO +: 2] == PIN_SEL_ALARM) begin
      calibration_status_pin <= summary;
    end else begin
      calibration_status_pin <= cal_done;
    end
  end

endmodule : link_sync_alarm_monitor
`default_nettype wire

// >>> rtl/link_sync_pkg.sv
// Shared constants for the link synchronization and alarm monitor pair
package link_sync_pkg;
  // Register word offsets (byte addresses)
  localparam logic [7:0] REG_CTRL        = 8'h00;
  localparam logic [7:0] REG_ALARM       = 8'h04;
  localparam logic [7:0] REG_ALARM_MASK  = 8'h08;
  localparam logic [7:0] REG_SUMMARY     = 8'h0c;
  localparam logic [7:0] REG_CLOCK_UPSET = 8'h10;
  localparam logic [7:0] REG_LANE_FIFO   = 8'h14;
  localparam logic [7:0] REG_LINK_STATE  = 8'h18;
  // Control register fields
  localparam int CTRL_LINK_EN    = 0;
  localparam int CTRL_ENC_64B    = 1;
  localparam int CTRL_SUBCLASS0  = 2;
  localparam int CTRL_PD_A       = 3;
  localparam int CTRL_PD_B       = 4;
  localparam int CTRL_GLOBAL_PD  = 5;
  localparam int CTRL_PIN_SEL_LO = 6;
  localparam int CTRL_KM1_LO     = 8;
  localparam logic [1:0] PIN_SEL_CAL   = 2'h0;
  localparam logic [1:0] PIN_SEL_ALARM = 2'h1;
  localparam logic [15:0] CTRL_RESET   = 16'h1f00;
  // Alarm bit positions
  localparam int ALM_W          = 6;
  localparam int ALM_CPLL       = 0;
  localparam int ALM_SPLL       = 1;
  localparam int ALM_LINK_DOWN  = 2;
  localparam int ALM_SYSREF     = 3;
  localparam int ALM_CLOCK      = 4;
  localparam int ALM_FIFO       = 5;
  localparam logic [ALM_W-1:0] ALARM_MASK_RESET = 6'h3f;
  // Link characters and sequence lengths
  localparam logic [7:0] CHAR_CGS        = 8'hbc;
  localparam logic [7:0] CHAR_ALIGN_START = 8'h1c;
  localparam int ILAS_MULTIFRAMES = 4;
  localparam int CGS_MIN_CHARS    = 4;
  // Transmitter states
  typedef enum logic [3:0] {
    TX_OFF  = 4'b0001,
    TX_CGS  = 4'b0010,
    TX_ILAS = 4'b0100,
    TX_DATA = 4'b1000
  } tx_state_e;
  // Receiver states
  typedef enum logic [2:0] {
    RX_SYNC  = 3'b001,
    RX_ALIGN = 3'b010,
    RX_RUN   = 3'b100
  } rx_state_e;
endpackage : link_sync_pkg

// >>> rtl/link_if.sv
// Serial link carrier between converter transmitter and logic receiver
`timescale 1ns/10ps
`default_nettype none
interface link_if #(parameter int LANES = 4);
  logic               sysref;
  logic               sync_n;
  logic [LANES*8-1:0] tx_data;
  logic [LANES-1:0]   tx_ctrl;
  modport device   (input sysref, input sync_n, output tx_data, output tx_ctrl);
  modport receiver (output sysref, output sync_n, input tx_data, input tx_ctrl);
endinterface : link_if
`default_nettype wire

// >>> rtl/link_rx_release.sv
// Logic-device receiver end: SYNC request, lane arrival and buffer release
`timescale 1ns/10ps
`default_nettype none
module link_rx_release
  import link_sync_pkg::*;
#(
  parameter int LANES = 4
) (
  input  wire logic               mclk,
  input  wire logic               rstn,
  input  wire logic [7:0]         frames_m1,
  input  wire logic [7:0]         rbd,
  input  wire logic               encoding_64b,
  input  wire logic               sysref_req,
  input  wire logic               resync_req,
  output logic                    release_pulse,
  output logic      [LANES*8-1:0] rx_data,
  output logic                    rx_valid,
  output logic      [LANES-1:0]   lanes_arrived,
  output logic                    late_arrival,
  link_if.receiver                link
);

  rx_state_e  state;
  rx_state_e  next_state;
  logic [7:0] lmfc_count;
  logic [2:0] cgs_count;
  logic       release_point;
  logic [LANES-1:0] arrive_now;

  always_ff @(posedge mclk or negedge rstn) begin
    if (!rstn) begin
      link.sysref <= 1'b0;
    end else begin
      link.sysref <= sysref_req;
    end
  end

  // Local multiframe clock, restarted by the SYSREF this end sends
  always_ff @(posedge mclk or negedge rstn) begin
    if (!rstn) begin
      lmfc_count <= 8'h0;
    end else if (link.sysref || lmfc_count >= frames_m1) begin
      lmfc_count <= 8'h0;
    end else begin
      lmfc_count <= lmfc_count + 8'h1;
    end
  end

  // Release point offset by RBD frames
  assign release_point = lmfc_count == rbd;

  always_comb begin
    for (int i = 0; i < LANES; i++) begin
      arrive_now[i] = link.tx_ctrl[i] && link.tx_data[i*8 +: 8] == CHAR_ALIGN_START;
    end
  end

  always_comb begin
    next_state = state;
    unique case (state)
      RX_SYNC:  if (encoding_64b || cgs_count == 3'(CGS_MIN_CHARS)) next_state = RX_ALIGN;
      // Release only when every lane is in
      RX_ALIGN: if (&lanes_arrived && release_point) next_state = RX_RUN;
      RX_RUN:   next_state = RX_RUN;
      default:  next_state = RX_SYNC;
    endcase
    if (resync_req) next_state = RX_SYNC;
  end

  always_ff @(posedge mclk or negedge rstn) begin
    if (!rstn) begin
      state <= RX_SYNC;
    end else begin
      state <= next_state;
    end
  end

  // SYNC held low while requesting CGS
  always_ff @(posedge mclk or negedge rstn) begin
    if (!rstn) begin
      link.sync_n <= 1'b0;
    end else begin
      link.sync_n <= encoding_64b || next_state != RX_SYNC;
    end
  end

  always_ff @(posedge mclk or negedge rstn) begin
    if (!rstn) begin
      cgs_count <= 3'h0;
    end else if (state == RX_SYNC && link.tx_ctrl[0] && link.tx_data[7:0] == CHAR_CGS) begin
      if (cgs_count != 3'(CGS_MIN_CHARS)) cgs_count <= cgs_count + 3'h1;
    end else begin
      cgs_count <= 3'h0;
    end
  end

  always_ff @(posedge mclk or negedge rstn) begin
    if (!rstn) begin
      lanes_arrived <= '0;
    end else if (state != RX_ALIGN) begin
      lanes_arrived <= '0;
    end else begin
      lanes_arrived <= lanes_arrived | arrive_now;
    end
  end

  // Arrival on the release point means latency may slip a period
  always_ff @(posedge mclk or negedge rstn) begin
    if (!rstn) begin
      late_arrival <= 1'b0;
    end else if (resync_req) begin
      late_arrival <= 1'b0;
    end else if (state == RX_ALIGN && |arrive_now && release_point) begin
      late_arrival <= 1'b1;
    end
  end

  always_ff @(posedge mclk or negedge rstn) begin
    if (!rstn) begin
      release_pulse <= 1'b0;
      rx_valid      <= 1'b0;
      rx_data       <= '0;
    end else begin
      release_pulse <= state == RX_ALIGN && next_state == RX_RUN;
      rx_valid      <= next_state == RX_RUN;
      rx_data       <= (next_state == RX_RUN) ? link.tx_data : '0;
    end
  end

endmodule : link_rx_release
`default_nettype wire

// >>> testbench/link_sync_alarm_monitor_asserts.sv
// Concurrent checks on the link carrier between the two ends
`timescale 1ns/10ps
`default_nettype none
module link_sync_alarm_monitor_asserts
  import link_sync_pkg::*;
#(
  parameter int LANES = 4
) (
  input  wire logic               mclk,
  input  wire logic               rstn,
  input  wire logic               sysref,
  input  wire logic               sync_n,
  input  wire logic [LANES*8-1:0] tx_data,
  input  wire logic [LANES-1:0]   tx_ctrl
);
  logic cgs;
  logic align;
  logic zero;
  assign cgs   = (tx_data[7:0] == CHAR_CGS) && tx_ctrl[0];
  assign align = (tx_data[7:0] == CHAR_ALIGN_START) && tx_ctrl[0];
  assign zero  = (tx_data == '0) && (tx_ctrl == '0);
  default clocking cb @(posedge mclk);
  endclocking
  default disable iff (!rstn);
  ////////////////////////////////////////
  chk_cgs_all_lanes: assert property (cgs |-> (tx_data == {LANES{CHAR_CGS}}) && (&tx_ctrl)) // comma fill
    else $error("comma not on all lanes");
  chk_align_all_lanes: assert property (align |-> (tx_data == {LANES{CHAR_ALIGN_START}}) && (&tx_ctrl)) // start
    else $error("start marker not on all lanes");
  chk_ctrl_lanes_equal: assert property ((tx_ctrl == '0) || (&tx_ctrl)) // lane pairing
    else $error("control flags differ between lanes");
  // Three low samples give the device time to fall back from alignment
  chk_cgs_sync_low: assert property ((!sync_n) [*3] ##0 tx_ctrl[0] |-> cgs) // sync request
    else $error("no comma while sync request low");
  chk_align_needs_sync: assert property (align |-> $past(sync_n)) // sync released
    else $error("alignment started under sync request");
  chk_align_single: assert property (align |=> !align) // single marker
    else $error("start marker longer than one cycle");
  // Holds for any multiframe of at least two frames
  chk_ilas_zero_run: assert property (align ##1 zero |=> zero [*6]) // alignment fill
    else $error("alignment fill broken early");
  chk_cgs_holds: assert property ((cgs && !sync_n) ##1 !sync_n |-> cgs || zero) // comma hold
    else $error("left comma state under sync request");
  ////////////////////////////////////////
  cov_cgs: cover property (cgs);
  cov_align: cover property (align);
  cov_sysref: cover property ($rose(sysref));
  cov_sync: cover property ($rose(sync_n));
endmodule : link_sync_alarm_monitor_asserts
`default_nettype wire

// >>> testbench/tb_link_sync_alarm_monitor.sv
// Bench for the converter link monitor facing its receiver end
`timescale 1ns/10ps
`default_nettype none
module tb_link_sync_alarm_monitor
  import link_sync_pkg::*;
;
  localparam int LANES = 4;
  localparam int EMB   = 16;
  logic        mclk, rstn, wr, rd, cpll_locked, spll_locked, clk_a_phase, clk_b_phase, powerdown_pin;
  logic        cal_done, calibration_status_pin, link_reset_n, serializer_powerdown, link_clock_gate_en;
  logic        lmfc_edge, encoding_64b, sysref_req, resync_req, release_pulse, rx_valid, late_arrival;
  logic [3:0]  fifo_ptr_upset, lanes_arrived;
  logic [7:0]  addr, frames_m1, rbd;
  logic [31:0] wdata, rdata, sample_data, rx_data;
  int          error_cnt, num_checks;
  link_if #(.LANES(LANES)) lnk ();
  link_sync_alarm_monitor #(.LANES(LANES), .EMB_FRAMES(EMB)) u_link_sync_alarm_monitor (
    .mclk(mclk), .rstn(rstn), .addr(addr), .wdata(wdata), .wr(wr), .rd(rd), .rdata(rdata),
    .cpll_locked(cpll_locked), .spll_locked(spll_locked), .clk_a_phase(clk_a_phase),
    .clk_b_phase(clk_b_phase), .fifo_ptr_upset(fifo_ptr_upset), .powerdown_pin(powerdown_pin),
    .cal_done(cal_done), .sample_data(sample_data), .calibration_status_pin(calibration_status_pin),
    .link_reset_n(link_reset_n), .serializer_powerdown(serializer_powerdown),
    .link_clock_gate_en(link_clock_gate_en), .lmfc_edge(lmfc_edge), .link(lnk));
  link_rx_release #(.LANES(LANES)) u_link_rx_release (
    .mclk(mclk), .rstn(rstn), .frames_m1(frames_m1), .rbd(rbd), .encoding_64b(encoding_64b),
    .sysref_req(sysref_req), .resync_req(resync_req), .release_pulse(release_pulse), .rx_data(rx_data),
    .rx_valid(rx_valid), .lanes_arrived(lanes_arrived), .late_arrival(late_arrival), .link(lnk));
  link_sync_alarm_monitor_asserts #(.LANES(LANES)) u_link_sync_alarm_monitor_asserts (
    .mclk(mclk), .rstn(rstn), .sysref(lnk.sysref), .sync_n(lnk.sync_n), .tx_data(lnk.tx_data),
    .tx_ctrl(lnk.tx_ctrl));
  initial mclk = 1'b0;
  always #12.5 mclk = ~mclk;
  ////////////////////////////////////////
  task automatic check(input string what, input logic [31:0] seen, input logic [31:0] exp);
    num_checks++;
    if (seen !== exp) begin
      error_cnt++;
      $display("mismatch %s expected %h seen %h", what, exp, seen);
    end
  endtask : check
  task automatic wr_reg(input logic [7:0] a, input logic [31:0] d);
    @(posedge mclk);
    addr  <= a;
    wdata <= d;
    wr    <= 1'b1;
    @(posedge mclk);
    wr <= 1'b0;
  endtask : wr_reg
  task automatic rd_reg(input logic [7:0] a, output logic [31:0] d);
    @(posedge mclk);
    addr <= a;
    rd   <= 1'b1;
    @(posedge mclk);
    rd <= 1'b0;
    #1;
    d = rdata;
  endtask : rd_reg
  task automatic rd_chk(input string what, input logic [7:0] a, input logic [31:0] exp,
                        input logic [31:0] m = 32'hffffffff);
    logic [31:0] d;
    rd_reg(a, d);
    check(what, d & m, exp);
  endtask : rd_chk
  task automatic wait_state(input logic [31:0] exp);
    logic [31:0] d;
    d = 32'h0;
    for (int i = 0; i < 200 && d !== exp; i++) rd_reg(REG_LINK_STATE, d);
    check("link state", d, exp);
  endtask : wait_state
  task automatic count_edges(input int n, input int exp);
    int c;
    c = 0;
    repeat (n) begin
      @(negedge mclk);
      if (lmfc_edge === 1'b1) c++;
    end
    check("frame clock edges", 32'(c), 32'(exp));
  endtask : count_edges
  task automatic sref;
    @(posedge mclk);
    sysref_req <= 1'b1;
    @(posedge mclk);
    sysref_req <= 1'b0;
  endtask : sref
  // Second pulse lands one period after the first; clear sits clear of capture
  task automatic sysref_seq(input int p, input logic [31:0] late);
    sref();
    repeat (2) @(posedge mclk);
    wr_reg(REG_ALARM, 32'h08);
    repeat (p - 6) @(posedge mclk);
    sref();
    rd_chk("aligned sysref", REG_ALARM, 32'h0, 32'h08);
    sref();
    repeat (3) @(posedge mclk);
    rd_chk("shifted sysref", REG_ALARM, late, 32'h08);
  endtask : sysref_seq
  task automatic link_outs(input logic [31:0] exp);
    repeat (2) @(posedge mclk);
    #1;
    check("link outputs", 32'({link_reset_n, serializer_powerdown, link_clock_gate_en}), exp);
  endtask : link_outs
  task automatic pin_is(input logic [31:0] exp);
    repeat (2) @(posedge mclk);
    #1;
    check("status pin", 32'(calibration_status_pin), exp);
  endtask : pin_is
  task automatic end_of_test;
    $display("checks %0d mismatches %0d", num_checks, error_cnt);
    if (error_cnt == 0 && num_checks > 0) begin
      $display("All checks passed");
    end else begin
      $display("Checks failed");
    end
    $finish;
  endtask : end_of_test
  ////////////////////////////////////////
  initial begin
    repeat (20000) @(posedge mclk);
    error_cnt++;
    end_of_test();
  end
  initial begin
    error_cnt = 0;
    num_checks = 0;
    {rstn, wr, rd, clk_a_phase, clk_b_phase, powerdown_pin, cal_done} = '0;
    {cpll_locked, spll_locked} = 2'h3;
    {addr, wdata, fifo_ptr_upset, rbd} = '0;
    {encoding_64b, sysref_req, resync_req} = '0;
    frames_m1 = 8'h1f;
    sample_data = 32'h5a3c96e1;
    repeat (8) @(posedge mclk);
    rstn <= 1'b1;
    rd_chk("control", REG_CTRL, {16'h0, CTRL_RESET}); // link off
    rd_chk("mask", REG_ALARM_MASK, {26'h0, ALARM_MASK_RESET}); // mask reset
    rd_chk("status", REG_ALARM, 32'h04); // link down
    rd_chk("summary", REG_SUMMARY, 32'h0); // all masked
    rd_chk("unmapped", 8'h1c, 32'h0); // unmapped offset
    link_outs(32'h2); // link held off
    $display("test reset done");
    @(posedge mclk);
    {cpll_locked, spll_locked} <= 2'h0;
    @(posedge mclk);
    {cpll_locked, spll_locked} <= 2'h3;
    rd_chk("pll alarms", REG_ALARM, 32'h07); // pll sources
    wr_reg(REG_ALARM, 32'h0);
    rd_chk("write zero", REG_ALARM, 32'h07); // no clear
    wr_reg(REG_ALARM, 32'h01);
    rd_chk("clear one", REG_ALARM, 32'h06); // sticky bits
    wr_reg(REG_ALARM, 32'h02);
    rd_chk("clear two", REG_ALARM, 32'h04); // sticky bits
    $display("test sticky done");
    wr_reg(REG_ALARM_MASK, 32'h3b);
    rd_chk("summary", REG_SUMMARY, 32'h1); // unmasked
    wr_reg(REG_CTRL, 32'h1f40);
    pin_is(32'h1); // alarm pin
    wr_reg(REG_ALARM_MASK, 32'h3f);
    rd_chk("summary", REG_SUMMARY, 32'h0); // masked
    pin_is(32'h0); // alarm pin
    @(posedge mclk);
    cal_done <= 1'b1;
    wr_reg(REG_CTRL, 32'h1f00);
    pin_is(32'h1); // normal pin
    $display("test mask done");
    wr_reg(REG_CTRL, 32'h1f01);
    link_outs(32'h5); // link running
    @(posedge mclk);
    fifo_ptr_upset <= 4'h4;
    @(posedge mclk);
    fifo_ptr_upset <= 4'h0;
    rd_chk("lane flags", REG_LANE_FIFO, 32'h4); // one lane
    rd_chk("fifo alarm", REG_ALARM, 32'h20, 32'h20); // fifo source
    wr_reg(REG_LANE_FIFO, 32'h0);
    rd_chk("lane flags", REG_LANE_FIFO, 32'h4); // no clear
    wr_reg(REG_CTRL, 32'h1f00);
    link_outs(32'h2); // link held off
    wr_reg(REG_CTRL, 32'h1f01);
    rd_chk("lane flags", REG_LANE_FIFO, 32'h0); // enable toggle
    $display("test fifo done");
    wr_reg(REG_CLOCK_UPSET, 32'h1);
    rd_chk("upset", REG_CLOCK_UPSET, 32'h0); // armed
    @(posedge mclk);
    clk_b_phase <= 1'b1;
    @(posedge mclk);
    clk_b_phase <= 1'b0;
    rd_chk("upset", REG_CLOCK_UPSET, 32'h1); // one cycle
    rd_chk("clock alarm", REG_ALARM, 32'h10, 32'h10); // clock source
    wr_reg(REG_CLOCK_UPSET, 32'h0);
    rd_chk("upset", REG_CLOCK_UPSET, 32'h1); // no clear
    wr_reg(REG_CLOCK_UPSET, 32'h1);
    rd_chk("upset", REG_CLOCK_UPSET, 32'h0); // host clear
    wr_reg(REG_CTRL, 32'h1f09);
    @(posedge mclk);
    clk_b_phase <= 1'b1;
    @(posedge mclk);
    clk_b_phase <= 1'b0;
    rd_chk("upset", REG_CLOCK_UPSET, 32'h0); // channel off
    wr_reg(REG_CTRL, 32'h1f21);
    wr_reg(REG_CTRL, 32'h1f01);
    rd_chk("upset", REG_CLOCK_UPSET, 32'h1); // mode exit
    wr_reg(REG_CLOCK_UPSET, 32'h1);
    @(posedge mclk);
    powerdown_pin <= 1'b1;
    repeat (2) @(posedge mclk);
    powerdown_pin <= 1'b0;
    rd_chk("upset", REG_CLOCK_UPSET, 32'h1); // pin exit
    wr_reg(REG_CLOCK_UPSET, 32'h1);
    rd_chk("upset", REG_CLOCK_UPSET, 32'h0); // host clear
    $display("test clock upset done");
    wr_reg(REG_CTRL, 32'h1f00);
    @(posedge mclk);
    resync_req <= 1'b1;
    @(posedge mclk);
    resync_req <= 1'b0;
    wr_reg(REG_CTRL, 32'h1f01);
    for (int i = 0; i < 400 && release_pulse !== 1'b1; i++) @(negedge mclk);
    check("release", 32'(release_pulse), 32'h1); // release point
    check("lanes", 32'(lanes_arrived), 32'hf); // all lanes
    check("rx valid", 32'(rx_valid), 32'h1); // data valid
    check("late arrival", 32'(late_arrival), 32'h0); // arrival window
    wait_state(32'h8); // data state reached
    repeat (100) @(posedge mclk);
    #1;
    check("rx data", rx_data, sample_data); // data path
    wr_reg(REG_ALARM, 32'h04);
    rd_chk("link down", REG_ALARM, 32'h0, 32'h04); // link up
    sysref_seq(32, 32'h08); // multiframe reset
    count_edges(128, 4); // multiframe period
    $display("test link 8b done");
    wr_reg(REG_CTRL, 32'h1f00);
    @(posedge mclk);
    resync_req <= 1'b1;
    @(posedge mclk);
    resync_req <= 1'b0;
    wr_reg(REG_CTRL, 32'h1f05);
    wait_state(32'h8); // subclass 0 sync
    sysref_seq(32, 32'h0); // sysref ignored
    count_edges(128, 4); // free running
    $display("test subclass0 done");
    wr_reg(REG_CTRL, 32'h1f00);
    frames_m1 <= 8'(EMB - 1);
    encoding_64b <= 1'b1;
    @(posedge mclk);
    resync_req <= 1'b1;
    @(posedge mclk);
    resync_req <= 1'b0;
    wr_reg(REG_CTRL, 32'h1f03);
    wait_state(32'h8); // block mode start
    sysref_seq(EMB, 32'h08); // multiblock reset
    count_edges(128, 128 / EMB); // multiblock period
    $display("test link 64b done");
    end_of_test();
  end
endmodule : tb_link_sync_alarm_monitor
`default_nettype wire
